// File: rtl/stripe_code_pkg.sv
// shared constants, types and coding functions of the stripe code encoder
`default_nettype none
package stripe_code_pkg;

	localparam logic [7:0]  SYNC_FIXED    = 8'h46;
	localparam logic [3:0]  SYNC_CODE     = 4'h0;
	localparam logic [3:0]  RESYNC_FIRST  = 4'h1;
	localparam logic [3:0]  RESYNC_LAST   = 4'hF;
	localparam logic [7:0]  LEAD_BYTE     = 8'h00;
	localparam logic [7:0]  TAIL_BYTE     = 8'h55;
	localparam logic [31:0] DETECT_POLY   = 32'h8000_0011;
	localparam logic [7:0]  FIELD_POLY    = 8'h1D;
	localparam logic [7:0]  GEN_C3        = 8'h0F;
	localparam logic [7:0]  GEN_C2        = 8'h36;
	localparam logic [7:0]  GEN_C1        = 8'h78;
	localparam logic [7:0]  GEN_C0        = 8'h40;
	localparam logic [3:0]  BLOCKS_MIN    = 4'h1;
	localparam logic [3:0]  BLOCKS_MAX    = 4'hC;
	localparam logic [2:0]  GROUP_LAST    = 3'h4;
	localparam logic [2:0]  TAIL_LAST     = 3'h5;
	localparam logic [5:0]  PARITY_GROUPS = 6'h04;
	localparam logic [3:0]  UNIT_BIT_LAST = 4'hF;

	typedef enum logic [2:0] {
		S_IDLE   = 3'b000,
		S_LEAD   = 3'b001,
		S_INFO   = 3'b011,
		S_DETECT = 3'b010,
		S_PARITY = 3'b110,
		S_TAIL   = 3'b111
	} frame_state_type;

	typedef struct packed {
		logic [15:0] chan;
		logic        info;
	} unit_type;

	// phase encoding, msb first; invert selects the outer-field mapping
	function automatic logic [15:0] phase_byte(input logic [7:0] d,
		input logic invert);
		logic [15:0] r;
		r = 16'h0000;
		for (int b = 7; b >= 0; b--) begin
			r[2*b+1] = d[b] ^ invert;
			r[2*b]   = ~(d[b] ^ invert);
		end
		return r;
	endfunction

	function automatic logic [15:0] sync_unit(input logic [3:0] code);
		logic [15:0] p;
		p = phase_byte({code, 4'h0}, 1'b1);
		return {SYNC_FIXED, p[15:8]};
	endfunction

	function automatic logic [31:0] detect_step(input logic [31:0] c,
		input logic [7:0] d);
		logic [31:0] r;
		r = c;
		for (int b = 7; b >= 0; b--) begin
			if (r[31] ^ d[b]) begin
				r = {r[30:0], 1'b0} ^ DETECT_POLY;
			end else begin
				r = {r[30:0], 1'b0};
			end
		end
		return r;
	endfunction

	function automatic logic [7:0] gf_mul(input logic [7:0] a,
		input logic [7:0] b);
		logic [7:0] r;
		logic [7:0] t;
		r = 8'h00;
		t = a;
		for (int i = 0; i < 8; i++) begin
			if (b[i]) begin
				r = r ^ t;
			end
			t = t[7] ? ({t[6:0], 1'b0} ^ FIELD_POLY) : {t[6:0], 1'b0};
		end
		return r;
	endfunction

	// one symbol into a systematic encoder, rem[31:24] is highest order
	function automatic logic [31:0] parity_step(input logic [31:0] rem,
		input logic [7:0] d);
		logic [7:0] fb;
		fb = d ^ rem[31:24];
		return {rem[23:16] ^ gf_mul(fb, GEN_C3),
			rem[15:8] ^ gf_mul(fb, GEN_C2),
			rem[7:0] ^ gf_mul(fb, GEN_C1),
			gf_mul(fb, GEN_C0)};
	endfunction

endpackage
`default_nettype wire

// File: rtl/stripe_pair_buffer.sv
// two-entry buffer with valid and ready on both sides
`timescale 1ns/1ns
`default_nettype none
module stripe_pair_buffer #(
	parameter int WIDTH = 8
) (
	input  wire logic             core_clk_in,
	input  wire logic             nrst_in,
	input  wire logic [WIDTH-1:0] fill_data_in,
	input  wire logic             fill_valid_in,
	output var  logic             fill_ready_out,
	output var  logic [WIDTH-1:0] drain_data_out,
	output var  logic             drain_valid_out,
	input  wire logic             drain_ready_in
);
	logic [WIDTH-1:0] slot [2];
	logic             wr_ptr;
	logic             rd_ptr;
	logic [1:0]       count;
	logic [1:0]       next_count;
	logic             push;
	logic             pop;

	assign push = fill_valid_in && fill_ready_out;
	assign pop  = drain_valid_out && drain_ready_in;
	assign drain_data_out  = slot[rd_ptr];
	assign drain_valid_out = count != 2'h0;

	always_comb begin
		next_count = count;
		if (push && !pop) begin
			next_count = count + 2'h1;
		end else if (pop && !push) begin
			next_count = count - 2'h1;
		end
	end

	always_ff @(posedge core_clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			count          <= 2'h0;
			fill_ready_out <= 1'b0;
			wr_ptr         <= 1'b0;
			rd_ptr         <= 1'b0;
		end else begin
			count          <= next_count;
			fill_ready_out <= next_count != 2'h2;
			wr_ptr         <= wr_ptr ^ push;
			rd_ptr         <= rd_ptr ^ pop;
		end
	end

	always_ff @(posedge core_clk_in) begin
		if (push) begin
			slot[wr_ptr] <= fill_data_in;
		end
	end
endmodule // stripe_pair_buffer
`default_nettype wire

// File: rtl/stripe_code_frame_encoder.sv
// stripe code frame encoder: fields, detect and parity codes, rz pulses
`timescale 1ns/1ns
`default_nettype none
// How it works
// - data field bit zero 01, one 10
// - outer fields use inverted bit mapping
// - rz pulse, at most half channel bit
// - lead, data, tail fields without gaps
// - lead field: sync byte, four 00
// - info bytes, detect bytes, parity bytes
// - resync before every four data bytes
// - tail: resync, four 55, resync
// - detect bit zero is last lsb
// - detect code: info mod x32+x31+x4+1
// - four reed-solomon interleaves, four parity each
// - interleave j takes bytes j+4i, detect j
// - sync: fixed 01000110 then four code bits
// - resyncs carry binary 1 to 15, then wrap to 1
module stripe_code_frame_encoder (
	input  wire logic       core_clk_in,
	input  wire logic       nrst_in,
	input  wire logic       start_in,
	input  wire logic [3:0] block_count_in,
	input  wire logic [7:0] info_data_in,
	input  wire logic       info_valid_in,
	output var  logic       info_ready_out,
	output var  logic       stripe_pulse_out,
	output var  logic       busy_out,
	output var  logic       done_out
);
	stripe_code_pkg::frame_state_type state;
	stripe_code_pkg::unit_type        unit;
	logic [2:0]  slot;
	logic [5:0]  grp;
	logic [5:0]  info_groups;
	logic [3:0]  resync_num;
	logic [31:0] detect;
	logic [3:0][31:0] parity;
	logic [1:0]  sidx;
	logic [7:0]  buf_data;
	logic        buf_valid;
	logic        buf_ready;
	logic [15:0] word;
	logic [3:0]  bit_cnt;
	logic        half;
	logic        loaded;
	logic        want;
	logic        fire;
	logic        unit_end;
	logic        start_ok;
	logic        resync_due;

	stripe_pair_buffer #(
		.WIDTH(8)
	) u_buffer (
		.core_clk_in    (core_clk_in),
		.nrst_in        (nrst_in),
		.fill_data_in   (info_data_in),
		.fill_valid_in  (info_valid_in),
		.fill_ready_out (info_ready_out),
		.drain_data_out (buf_data),
		.drain_valid_out(buf_valid),
		.drain_ready_in (buf_ready)
	);

	assign sidx     = 2'(slot - 3'h1);
	assign unit_end = loaded && half
		&& (bit_cnt == stripe_code_pkg::UNIT_BIT_LAST);
	assign want     = (state != stripe_code_pkg::S_IDLE)
		&& (!loaded || unit_end);
	assign fire     = want && (!unit.info || buf_valid);
	assign buf_ready = fire && unit.info;
	// a start waits until the last tail unit has left the shifter
	assign start_ok = start_in && !loaded
		&& block_count_in >= stripe_code_pkg::BLOCKS_MIN
		&& block_count_in <= stripe_code_pkg::BLOCKS_MAX;
	// resyncs head each data group and close the tail
	assign resync_due = fire && state != stripe_code_pkg::S_LEAD
		&& (slot == 3'h0 || (state == stripe_code_pkg::S_TAIL
		&& slot == stripe_code_pkg::TAIL_LAST));

	// next 16 channel bits to send
	always_comb begin
		unit.info = 1'b0;
		unit.chan = 16'h0000;
		case (state)
			stripe_code_pkg::S_LEAD: begin
				if (slot == 3'h0) begin
					unit.chan = stripe_code_pkg::sync_unit(
						stripe_code_pkg::SYNC_CODE);
				end else begin
					unit.chan = stripe_code_pkg::phase_byte(
						stripe_code_pkg::LEAD_BYTE, 1'b1);
				end
			end
			stripe_code_pkg::S_INFO: begin
				if (slot == 3'h0) begin
					unit.chan = stripe_code_pkg::sync_unit(
						resync_num);
				end else begin
					unit.info = 1'b1;
					unit.chan = stripe_code_pkg::phase_byte(
						buf_data, 1'b0);
				end
			end
			stripe_code_pkg::S_DETECT: begin
				if (slot == 3'h0) begin
					unit.chan = stripe_code_pkg::sync_unit(resync_num);
				end else begin
					unit.chan = stripe_code_pkg::phase_byte(
						detect[8*(3-sidx) +: 8], 1'b0);
				end
			end
			stripe_code_pkg::S_PARITY: begin
				if (slot == 3'h0) begin
					unit.chan = stripe_code_pkg::sync_unit(resync_num);
				end else begin
					unit.chan = stripe_code_pkg::phase_byte(
						parity[grp[1:0]][8*(3-sidx) +: 8],
						1'b0);
				end
			end
			stripe_code_pkg::S_TAIL: begin
				if (slot == 3'h0 || slot == stripe_code_pkg::TAIL_LAST) begin
					unit.chan = stripe_code_pkg::sync_unit(
						resync_num);
				end else begin
					unit.chan = stripe_code_pkg::phase_byte(
						stripe_code_pkg::TAIL_BYTE, 1'b1);
				end
			end
			default: begin
				unit.chan = 16'h0000;
			end
		endcase
	end

	// field sequencer
	always_ff @(posedge core_clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			state       <= stripe_code_pkg::S_IDLE;
			slot        <= 3'h0;
			grp         <= 6'h00;
			info_groups <= 6'h00;
		end else begin
			case (state)
				stripe_code_pkg::S_IDLE: begin
					if (start_ok) begin
						state       <= stripe_code_pkg::S_LEAD;
						slot        <= 3'h0;
						grp         <= 6'h00;
						info_groups <= {block_count_in, 2'b00} - 6'h01;
					end
				end
				stripe_code_pkg::S_LEAD: begin
					if (fire) begin
						if (slot == stripe_code_pkg::GROUP_LAST) begin
							state <= stripe_code_pkg::S_INFO;
							slot  <= 3'h0;
						end else begin
							slot <= slot + 3'h1;
						end
					end
				end
				stripe_code_pkg::S_INFO: begin
					if (fire) begin
						if (slot != stripe_code_pkg::GROUP_LAST) begin
							slot <= slot + 3'h1;
						end else if (grp == info_groups - 6'h01) begin
							state <= stripe_code_pkg::S_DETECT;
							slot  <= 3'h0;
						end else begin
							grp  <= grp + 6'h01;
							slot <= 3'h0;
						end
					end
				end
				stripe_code_pkg::S_DETECT: begin
					if (fire) begin
						if (slot == stripe_code_pkg::GROUP_LAST) begin
							state <= stripe_code_pkg::S_PARITY;
							grp   <= 6'h00;
							slot  <= 3'h0;
						end else begin
							slot <= slot + 3'h1;
						end
					end
				end
				stripe_code_pkg::S_PARITY: begin
					if (fire) begin
						if (slot != stripe_code_pkg::GROUP_LAST) begin
							slot <= slot + 3'h1;
						end else if (grp
							== stripe_code_pkg::PARITY_GROUPS - 6'h01) begin
							state <= stripe_code_pkg::S_TAIL;
							slot  <= 3'h0;
						end else begin
							grp  <= grp + 6'h01;
							slot <= 3'h0;
						end
					end
				end
				stripe_code_pkg::S_TAIL: begin
					if (fire) begin
						if (slot == stripe_code_pkg::TAIL_LAST) begin
							state <= stripe_code_pkg::S_IDLE;
						end else begin
							slot <= slot + 3'h1;
						end
					end
				end
				default: begin
					state <= stripe_code_pkg::S_IDLE;
				end
			endcase
		end
	end

	// resync numbering, wraps from 15 back to 1
	always_ff @(posedge core_clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			resync_num <= stripe_code_pkg::RESYNC_FIRST;
		end else if (state == stripe_code_pkg::S_IDLE) begin
			resync_num <= stripe_code_pkg::RESYNC_FIRST;
		end else if (resync_due) begin
			if (resync_num == stripe_code_pkg::RESYNC_LAST) begin
				resync_num <= stripe_code_pkg::RESYNC_FIRST;
			end else begin
				resync_num <= resync_num + 4'h1;
			end
		end
	end

	// detect code over information bytes
	always_ff @(posedge core_clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			detect <= 32'h0000_0000;
		end else if (state == stripe_code_pkg::S_IDLE) begin
			detect <= 32'h0000_0000;
		end else if (buf_ready) begin
			detect <= stripe_code_pkg::detect_step(detect,
				buf_data);
		end
	end

	// four interleaved parity encoders
	always_ff @(posedge core_clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			parity <= '0;
		end else if (state == stripe_code_pkg::S_IDLE) begin
			parity <= '0;
		end else if (buf_ready) begin
			parity[sidx] <= stripe_code_pkg::parity_step(parity[sidx],
				buf_data);
		end else if (fire && state == stripe_code_pkg::S_DETECT
			&& slot != 3'h0) begin
			parity[sidx] <= stripe_code_pkg::parity_step(parity[sidx],
				detect[8*(3-sidx) +: 8]);
		end
	end

	// channel bit shifter, two clocks per channel bit
	always_ff @(posedge core_clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			word    <= 16'h0000;
			bit_cnt <= 4'h0;
			half    <= 1'b0;
			loaded  <= 1'b0;
		end else if (fire) begin
			word    <= unit.chan;
			bit_cnt <= 4'h0;
			half    <= 1'b0;
			loaded  <= 1'b1;
		end else if (loaded) begin
			half <= ~half;
			if (half) begin
				if (bit_cnt == stripe_code_pkg::UNIT_BIT_LAST) begin
					loaded <= 1'b0;
				end else begin
					bit_cnt <= bit_cnt + 4'h1;
					word    <= {word[14:0], 1'b0};
				end
			end
		end
	end

	// registered outputs
	always_ff @(posedge core_clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			stripe_pulse_out <= 1'b0;
			busy_out         <= 1'b0;
			done_out         <= 1'b0;
		end else begin
			// pulse only in the first clock of a bit keeps stripes narrow
			stripe_pulse_out <= loaded && !half && word[15];
			busy_out         <= (state != stripe_code_pkg::S_IDLE) || loaded;
			done_out         <= unit_end && (state == stripe_code_pkg::S_IDLE);
		end
	end
endmodule // stripe_code_frame_encoder
`default_nettype wire

// File: sim/stripe_code_frame_encoder_monitor.sv
// port checks of the stripe code frame encoder
`timescale 1ns/1ns
`default_nettype none
module stripe_frame_checker (
	input  wire logic       core_clk_in,
	input  wire logic       nrst_in,
	input  wire logic       start_in,
	input  wire logic [3:0] block_count_in,
	input  wire logic [7:0] info_data_in,
	input  wire logic       info_valid_in,
	input  wire logic       info_ready_out,
	input  wire logic       stripe_pulse_out,
	input  wire logic       busy_out,
	input  wire logic       done_out
);
	logic [3:0] quiet;
	logic       p;
	logic       go;
	logic       n_ok;
	assign p = stripe_pulse_out;
	assign n_ok = block_count_in >= 4'h1 && block_count_in <= 4'hC;
	assign go = start_in && quiet >= 4'h4;
	// cycles since the last start or frame activity
	always_ff @(posedge core_clk_in or negedge nrst_in) begin
		if (!nrst_in) quiet <= 4'h0;
		else if (start_in || busy_out || done_out) quiet <= 4'h0;
		else if (quiet != 4'hF) quiet <= quiet + 4'h1;
	end
	default clocking @(posedge core_clk_in); endclocking
	default disable iff (!nrst_in);
	sequence s_fixed;
		!p ##2 p ##2 !p ##2 !p ##2 !p ##2 p ##2 p ##2 !p;
	endsequence
	sequence s_zeros;
		p ##2 !p ##2 p ##2 !p ##2 p ##2 !p ##2 p ##2 !p;
	endsequence
	AST_RZ_HALF: assert property (p |=> !p)
		else $error("stripe pulse longer than half a bit");
	AST_START_SYNC: assert property (go && n_ok |-> ##3 s_fixed ##2 s_zeros)
		else $error("frame does not open with the sync byte");
	AST_LEAD_ZERO: assert property (go && n_ok |-> ##35 s_zeros ##2 s_zeros)
		else $error("lead field byte is not zero");
	AST_BUSY_RISE: assert property (go && n_ok |-> ##[1:3] busy_out)
		else $error("busy missing after start");
	AST_REFUSE_N: assert property (go && !n_ok |=> !busy_out [*2])
		else $error("bad block count started a frame");
	AST_DONE_ONE: assert property (done_out |=> !done_out [*2])
		else $error("done longer than one pulse");
	AST_READY_FALL: assert property ($fell(info_ready_out) |->
		$past(info_valid_in && info_ready_out))
		else $error("ready fell without a byte taken");
	AST_IDLE_QUIET: assert property (quiet >= 4'h4 |-> !p)
		else $error("stripe outside a frame");
endmodule // stripe_frame_checker
bind stripe_code_frame_encoder stripe_frame_checker u_checker (
	.core_clk_in(core_clk_in), .nrst_in(nrst_in), .start_in(start_in),
	.block_count_in(block_count_in), .info_data_in(info_data_in),
	.info_valid_in(info_valid_in), .info_ready_out(info_ready_out),
	.stripe_pulse_out(stripe_pulse_out), .busy_out(busy_out),
	.done_out(done_out));
`default_nettype wire

// File: sim/stripe_writer_model.sv
// stripe writer model: collects channel bits from the rz pulse train
`timescale 1ns/1ns
`default_nettype none
module stripe_writer_model (
	input  wire logic core_clk_in,
	input  wire logic armed_in,
	input  wire logic clear_in,
	input  wire logic stripe_pulse_in
);
	logic bits [0:8191];
	int   bit_cnt = 0;
	int   wide_cnt = 0;
	logic half = 1'b0;
	always @(posedge core_clk_in) begin
		if (clear_in) begin
			bit_cnt = 0;
			wide_cnt = 0;
		end
		if (!armed_in) begin
			half = 1'b0;
		end else if (!half) begin
			bits[bit_cnt] = stripe_pulse_in;
			bit_cnt = bit_cnt + 1;
			half = 1'b1;
		end else begin
			// second half of each channel bit must stay dark
			if (stripe_pulse_in !== 1'b0) wide_cnt = wide_cnt + 1;
			half = 1'b0;
		end
	end
endmodule // stripe_writer_model
`default_nettype wire

// File: sim/stripe_code_frame_encoder_test.sv
// testbench of the stripe code frame encoder
`timescale 1ns/1ns
`default_nettype none
module stripe_code_frame_encoder_test;
	logic       core_clk_in = 1'b0;
	logic       nrst_in = 1'b0;
	logic       start_in = 1'b0;
	logic [3:0] block_count_in = 4'h0;
	logic [7:0] info_data_in = 8'h00;
	logic       info_valid_in = 1'b0;
	logic       armed = 1'b0;
	logic       clear = 1'b0;
	logic       info_ready_out, stripe_pulse_out, busy_out, done_out;
	int         error_cnt = 0;
	int         samples_checked = 0;
	int         cycles = 0;
	logic       exp_q [$];
	always #4 core_clk_in = ~core_clk_in;
	stripe_code_frame_encoder dut (.core_clk_in(core_clk_in),
		.nrst_in(nrst_in), .start_in(start_in),
		.block_count_in(block_count_in), .info_data_in(info_data_in),
		.info_valid_in(info_valid_in), .info_ready_out(info_ready_out),
		.stripe_pulse_out(stripe_pulse_out), .busy_out(busy_out),
		.done_out(done_out));
	stripe_writer_model model (.core_clk_in(core_clk_in),
		.armed_in(armed), .clear_in(clear),
		.stripe_pulse_in(stripe_pulse_out));
	task automatic check(input logic ok, input string msg);
		samples_checked++;
		if (ok !== 1'b1) begin
			error_cnt++;
			$display("unexpected at %0t: %s", $time, msg);
		end
	endtask
	task automatic conclude();
		$display("checks %0d mismatches %0d", samples_checked, error_cnt);
		if (error_cnt == 0 && samples_checked > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask
	always @(posedge core_clk_in) begin
		cycles++;
		if (cycles == 20000) begin
			error_cnt++;
			conclude();
		end
	end
	function automatic logic [7:0] gm(input logic [7:0] a,
		input logic [7:0] b);
		logic [7:0] r;
		r = 8'h00;
		for (int i = 0; i < 8; i++) begin
			if (b[i]) r = r ^ a;
			a = {a[6:0], 1'b0} ^ (a[7] ? 8'h1D : 8'h00);
		end
		return r;
	endfunction
	// phase encode one byte msb first, inv gives the outer mapping
	function automatic void put(input logic [7:0] d, input logic inv);
		for (int b = 7; b >= 0; b--) begin
			exp_q.push_back(d[b] ^ inv);
			exp_q.push_back(~(d[b] ^ inv));
		end
	endfunction
	function automatic void sync(input logic [3:0] c);
		logic [7:0] fx;
		fx = 8'h46;
		for (int b = 7; b >= 0; b--) exp_q.push_back(fx[b]);
		for (int b = 3; b >= 0; b--) begin
			exp_q.push_back(~c[b]);
			exp_q.push_back(c[b]);
		end
	endfunction
	task automatic run_frame(input int n, input bit poke);
		logic [7:0]  info [$];
		logic [7:0]  d [4];
		logic [7:0]  r [4][4];
		logic [7:0]  fb;
		logic [31:0] crc;
		int          rs;
		int          bad;
		int          t;
		crc = 32'h0;
		rs = 0;
		bad = 0;
		t = 0;
		exp_q = {};
		for (int k = 0; k < 16 * n - 4; k++) info.push_back(8'(k * 29 + 7));
		foreach (info[k]) begin
			for (int b = 7; b >= 0; b--) begin
				fb = {7'h00, crc[31] ^ info[k][b]};
				crc = {crc[30:0], 1'b0} ^ (fb[0] ? 32'h8000_0011 : 32'h0);
			end
		end
		for (int j = 0; j < 4; j++) begin
			d[j] = crc[31 - 8 * j -: 8];
			r[j] = '{default: 8'h00};
			for (int i = 0; i < 4 * n; i++) begin
				fb = (i < 4 * n - 1 ? info[j + 4 * i] : d[j]) ^ r[j][0];
				r[j][0] = r[j][1] ^ gm(fb, 8'h0F);
				r[j][1] = r[j][2] ^ gm(fb, 8'h36);
				r[j][2] = r[j][3] ^ gm(fb, 8'h78);
				r[j][3] = gm(fb, 8'h40);
			end
		end
		sync(4'h0);
		for (int k = 0; k < 4; k++) put(8'h00, 1'b1);
		for (int k = 0; k < 16 * n + 16; k++) begin
			if (k % 4 == 0) begin
				rs = rs % 15 + 1;
				sync(4'(rs));
			end
			put(k < 16 * n - 4 ? info[k] : k < 16 * n ? d[k - 16 * n + 4] :
				r[(k - 16 * n) / 4][k % 4], 1'b0);
		end
		rs = rs % 15 + 1;
		sync(4'(rs));
		for (int k = 0; k < 4; k++) put(8'h55, 1'b1);
		rs = rs % 15 + 1;
		sync(4'(rs));
		fork
			begin
				foreach (info[k]) begin
					info_data_in <= info[k];
					info_valid_in <= 1'b1;
					@(posedge core_clk_in);
					while (info_ready_out !== 1'b1) @(posedge core_clk_in);
				end
				info_valid_in <= 1'b0;
			end
			begin
				@(posedge core_clk_in);
				block_count_in <= 4'(n);
				start_in <= 1'b1;
				clear <= 1'b1;
				@(posedge core_clk_in);
				start_in <= 1'b0;
				clear <= 1'b0;
				repeat (2) @(posedge core_clk_in);
				armed <= 1'b1;
				while (done_out !== 1'b1 && t < 9000) begin
					@(posedge core_clk_in);
					t++;
					start_in <= poke && t == 100;
				end
				armed <= 1'b0;
			end
		join
		check(t < 9000, "frame never finished");
		check(model.bit_cnt == exp_q.size(), "frame length");
		foreach (exp_q[i]) if (model.bits[i] !== exp_q[i]) bad++;
		check(bad == 0, "channel bits differ");
		check(model.wide_cnt == 0, "stripe too wide");
		repeat (6) @(posedge core_clk_in);
		check(busy_out === 1'b0, "busy after frame");
	endtask
	task automatic test_reset();
		repeat (16) @(posedge core_clk_in);
		check({busy_out, done_out, stripe_pulse_out} === 3'h0, "reset out");
		nrst_in <= 1'b1;
		repeat (2) @(posedge core_clk_in);
		check(info_ready_out === 1'b1, "ready after reset");
		$display("test reset finished");
	endtask
	task automatic test_bad_count();
		logic [3:0] bad_n [3];
		bad_n = '{4'h0, 4'hD, 4'hF};
		foreach (bad_n[i]) begin
			repeat (5) @(posedge core_clk_in);
			block_count_in <= bad_n[i];
			start_in <= 1'b1;
			@(posedge core_clk_in);
			start_in <= 1'b0;
			repeat (4) @(posedge core_clk_in);
			check(busy_out === 1'b0, "bad count started");
		end
		$display("test bad count finished");
	endtask
	task automatic test_frame_small();
		run_frame(1, 1'b0);
		$display("test small frame finished");
	endtask
	task automatic test_frame_wrap();
		run_frame(3, 1'b1);
		$display("test wrap frame finished");
	endtask
	initial begin
		test_reset();
		test_bad_count();
		test_frame_small();
		test_frame_wrap();
		conclude();
	end
endmodule // stripe_code_frame_encoder_test
`default_nettype wire
